/* File: inc/match_timer_pkg.sv */
// constants shared by the dual byte match timer
package match_timer_pkg;

  // ****************************************
  // bus layout
  // ****************************************
  localparam int unsigned PADDR_W = 18;
  localparam int unsigned PDATA_W = 32;

  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_LOW_RELOAD  = 16'h7F18;
  localparam logic [15:0] IDX_HIGH_RELOAD = 16'h7F19;
  localparam logic [15:0] IDX_LOW_COUNT   = 16'h7F1A;
  localparam logic [15:0] IDX_HIGH_COUNT  = 16'h7F1B;
  localparam logic [15:0] IDX_RUN_CTRL    = 16'h7F1C;
  localparam logic [15:0] IDX_CAP_CTRL    = 16'h7F1D;
  localparam logic [15:0] IDX_CLK_CTRL    = 16'h7F1E;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned C0_HIGH_COUNT_ENABLE  = 7;
  localparam int unsigned C0_HIGH_MATCH_FLAG  = 6;
  localparam int unsigned C0_HIE   = 5;
  localparam int unsigned C0_SPLIT = 4;
  localparam int unsigned C0_RDSEL = 3;
  localparam int unsigned C0_RUN   = 2;
  localparam int unsigned C0_FLG   = 1;
  localparam int unsigned C0_IE    = 0;
  localparam int unsigned C1_SEL_HI = 4;
  localparam int unsigned C1_SEL_LO = 3;
  localparam int unsigned C1_HCFLG  = 2;
  localparam int unsigned C1_LCFLG  = 1;
  localparam int unsigned C1_CAPTURE_IRQ_ENABLE   = 0;
  localparam int unsigned C2_CK_HI  = 7;
  localparam int unsigned C2_CK_LO  = 6;
  localparam int unsigned C2_EVENT_SOURCE_SELECT  = 5;
  localparam int unsigned C2_PR_HI  = 3;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] PRE_RESET  = 4'h0;
  localparam logic [1:0] CK_SYSTEM  = 2'h0;
  localparam logic [1:0] CK_EVENT   = 2'h1;
  localparam logic [1:0] CK_AUX_OSCILLATOR_ZERO    = 2'h2;
  localparam logic [1:0] CK_AUX_OSCILLATOR_ONE    = 2'h3;
  // shared interrupt vector served by the request output
  localparam logic [15:0] IRQ_VECTOR = 16'h801C;

endpackage

/* File: rtl/match_timer.sv */
// dual byte match timer with prescaler, capture and apb registers
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - low buffer tracks reload, loads at zero
// - high buffer tracks reload, loads at zero
// - match when buffer equals counter byte, both bytes in 16-bit
// - low counter read only, counts prescaler
// - high counts overflow or prescaler when split
// - read select picks counters or captures
// - high run bit stops high counter split
// - high match flag sticky, split mode
// - high enable and flag request interrupt
// - width select: one 16-bit or two 8-bit
// - run bit stops timer at zero
// - low match flag sticky on match
// - low enable and flag request interrupt
// - capture source maps low trigger pins
// - split high trigger uses other pins
// - high capture flag only in split
// - low capture flag on low update
// - capture enable and flag request interrupt
// - clock select picks prescaler count clock
// - event source picks pin two or three
// - prescaler period is divider plus one
// - prescaler and counters clear on match/stop
// - prescaler runs with run bit, or high run bit when split
// - split event mode with pin two source, low counts pin two
// - capture copies current counter bytes
module match_timer
  import match_timer_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [PDATA_W-1:0] pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [PDATA_W-1:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               event_pin_zero,
  input  wire logic               event_pin_one,
  input  wire logic               event_pin_two,
  input  wire logic               event_pin_three,
  input  wire logic               event_pin_four,
  input  wire logic               event_pin_five,
  input  wire logic               aux_oscillator_zero,
  input  wire logic               aux_oscillator_one,
  output logic                    irq_request,
  output logic                    low_match,
  output logic                    high_match
);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [7:0] pins_async;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] sync3_reg;
  logic [7:0] ev;

  assign pins_async = {aux_oscillator_one, aux_oscillator_zero,
                       event_pin_five, event_pin_four,
                       event_pin_three, event_pin_two,
                       event_pin_one, event_pin_zero};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= pins_async[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
      assign ev[gi] = sync2_reg[gi] & ~sync3_reg[gi];
    end
  endgenerate

  // ****************************************
  // apb decode
  // ****************************************
  logic [7:0]  low_reload_reg;
  logic [7:0]  high_reload_reg;
  logic        high_count_enable_reg;
  logic        high_match_flag_reg;
  logic        hie_reg;
  logic        split_reg;
  logic        rdsel_reg;
  logic        run_reg;
  logic        flg_reg;
  logic        ie_reg;
  logic [1:0]  cap_sel_reg;
  logic        hcflg_reg;
  logic        lcflg_reg;
  logic        capture_irq_enable_reg;
  logic [1:0]  count_clock_select_reg;
  logic        event_source_select_reg;
  logic [3:0]  pr_reg;
  logic [7:0]  lcnt_reg;
  logic [7:0]  hcnt_reg;
  logic [7:0]  lbuf_reg;
  logic [7:0]  hbuf_reg;
  logic [7:0]  lcap_reg;
  logic [7:0]  hcap_reg;
  logic [3:0]  pre_reg;
  logic [7:0]  rd_byte;

  wire [15:0] word_idx = paddr[PADDR_W-1:2];
  wire        aligned  = (paddr[1:0] == 2'h0);
  wire hit_lrl = aligned & (word_idx == IDX_LOW_RELOAD);
  wire hit_hrl = aligned & (word_idx == IDX_HIGH_RELOAD);
  wire hit_lct = aligned & (word_idx == IDX_LOW_COUNT);
  wire hit_hct = aligned & (word_idx == IDX_HIGH_COUNT);
  wire hit_c0  = aligned & (word_idx == IDX_RUN_CTRL);
  wire hit_c1  = aligned & (word_idx == IDX_CAP_CTRL);
  wire hit_c2  = aligned & (word_idx == IDX_CLK_CTRL);
  wire mapped  = hit_lrl | hit_hrl | hit_lct | hit_hct
               | hit_c0 | hit_c1 | hit_c2;

  // one wait state: answer is prepared, then completes
  wire access  = psel & penable & ~pready;
  wire done    = psel & penable & pready;
  wire wr_lane = done & pwrite & pstrb[0] & mapped;
  wire w_lrl   = wr_lane & hit_lrl;
  wire w_hrl   = wr_lane & hit_hrl;
  wire w_c0    = wr_lane & hit_c0;
  wire w_c1    = wr_lane & hit_c1;
  wire w_c2    = wr_lane & hit_c2;
  wire [7:0] wb = pwdata[7:0];

  // ****************************************
  // mode and clock selection
  // ****************************************
  // width select
  wire split    = split_reg;
  wire low_run  = run_reg;
  // high run only in split mode
  wire high_run = split ? high_count_enable_reg : run_reg;
  wire pre_run  = run_reg | (split & high_count_enable_reg);
  wire low_direct = split & (count_clock_select_reg == CK_EVENT) & ~event_source_select_reg;

  wire pre_tick = (count_clock_select_reg == CK_EVENT) ? (event_source_select_reg ? ev[3] : (split | ev[2]))
                : (count_clock_select_reg == CK_AUX_OSCILLATOR_ZERO)  ? ev[6]
                : (count_clock_select_reg == CK_AUX_OSCILLATOR_ONE)  ? ev[7] : 1'b1;

  // ****************************************
  // prescaler and counters
  // ****************************************
  // period of divider plus one
  wire pre_match = pre_run & pre_tick & (pre_reg == pr_reg);

  // prescaler clears on stop or match
  wire [3:0] pre_next = (!pre_run || pre_match) ? PRE_RESET
                      : pre_tick ? pre_reg + 4'h1 : pre_reg;

  wire low_clk  = low_direct ? ev[2] : pre_match;
  wire low_eq   = (lcnt_reg == lbuf_reg);
  wire high_eq  = (hcnt_reg == hbuf_reg);
  wire full_eq  = low_eq & high_eq;
  wire low_hit  = low_run & low_clk & (split ? low_eq : full_eq);
  wire low_ovf  = low_run & low_clk & ~low_hit & (lcnt_reg == 8'hFF);
  wire high_clk = split ? pre_match : low_ovf;
  wire high_hit = split ? (high_count_enable_reg & pre_match & high_eq) : low_hit;

  wire [7:0] lcnt_next = (!low_run || low_hit) ? BYTE_RESET
                       : low_clk ? lcnt_reg + 8'h01 : lcnt_reg;
  // high byte clears on stop or match
  wire [7:0] hcnt_next = (!high_run || high_hit) ? BYTE_RESET
                       : high_clk ? hcnt_reg + 8'h01 : hcnt_reg;

  wire low_step  = low_run & low_clk;
  wire high_step = high_run & (high_clk | high_hit);

  wire [7:0] lbuf_next = !low_run ? low_reload_reg
                       : (low_step && lcnt_next == BYTE_RESET)
                       ? low_reload_reg : lbuf_reg;
  wire [7:0] hbuf_next = !high_run ? high_reload_reg
                       : (high_step && hcnt_next == BYTE_RESET)
                       ? high_reload_reg : hbuf_reg;

  // ****************************************
  // capture triggers
  // ****************************************
  // low trigger mapping
  wire low_trig   = cap_sel_reg[1] ? (cap_sel_reg[0] ? ev[5] : ev[4])
                                   : (cap_sel_reg[0] ? ev[2] : ev[0]);
  wire split_trig = cap_sel_reg[1] ? (cap_sel_reg[0] ? ev[4] : ev[5])
                                   : (cap_sel_reg[0] ? ev[3] : ev[1]);

  wire high_trig = split ? split_trig : low_trig;
  wire [7:0] lcap_next = low_trig  ? lcnt_reg : lcap_reg;
  wire [7:0] hcap_next = high_trig ? hcnt_reg : hcap_reg;

  // ****************************************
  // sticky flags
  // ****************************************
  // low match flag set
  wire flg_set   = low_hit;
  wire high_match_flag_set  = split & high_hit;
  wire lcflg_set = low_trig;
  // high capture flag only when split
  wire hcflg_set = split & split_trig;

  // a written zero clears, a one keeps
  wire flg_keep   = flg_reg   & (~w_c0 | wb[C0_FLG]);
  wire high_match_flag_keep  = high_match_flag_reg  & (~w_c0 | wb[C0_HIGH_MATCH_FLAG]);
  wire lcflg_keep = lcflg_reg & (~w_c1 | wb[C1_LCFLG]);
  wire hcflg_keep = hcflg_reg & (~w_c1 | wb[C1_HCFLG]);

  wire flg_next   = flg_set   | flg_keep;
  wire high_match_flag_next  = high_match_flag_set  | high_match_flag_keep;
  wire lcflg_next = lcflg_set | lcflg_keep;
  wire hcflg_next = hcflg_set | hcflg_keep;

  wire irq_low  = ie_reg & flg_reg;
  wire irq_high = split & hie_reg & high_match_flag_reg;
  wire irq_cap  = capture_irq_enable_reg & (lcflg_reg | hcflg_reg);
  wire irq_next = irq_low | irq_high | irq_cap;

  // ****************************************
  // read data
  // ****************************************
  // counter or capture view
  assign rd_byte = hit_lrl ? low_reload_reg
                 : hit_hrl ? high_reload_reg
                 : hit_lct ? (rdsel_reg ? lcap_reg : lcnt_reg)
                 : hit_hct ? (rdsel_reg ? hcap_reg : hcnt_reg)
                 : hit_c0  ? {high_count_enable_reg, high_match_flag_reg, hie_reg, split_reg,
                              rdsel_reg, run_reg, flg_reg, ie_reg}
                 : hit_c1  ? {3'h0, cap_sel_reg, hcflg_reg, lcflg_reg, capture_irq_enable_reg}
                 : hit_c2  ? {count_clock_select_reg, event_source_select_reg, 1'b0, pr_reg} : BYTE_RESET;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= access;
      pslverr <= access & ~mapped;
      prdata  <= access ? {24'h000000, rd_byte} : '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      low_reload_reg  <= BYTE_RESET;
      high_reload_reg <= BYTE_RESET;
    end
    else
    begin
      if (w_lrl)
        low_reload_reg <= wb;
      if (w_hrl)
        high_reload_reg <= wb;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      high_count_enable_reg  <= 1'b0;
      hie_reg   <= 1'b0;
      split_reg <= 1'b0;
      rdsel_reg <= 1'b0;
      run_reg   <= 1'b0;
      ie_reg    <= 1'b0;
    end
    else if (w_c0)
    begin
      high_count_enable_reg  <= wb[C0_HIGH_COUNT_ENABLE];
      hie_reg   <= wb[C0_HIE];
      split_reg <= wb[C0_SPLIT];
      rdsel_reg <= wb[C0_RDSEL];
      run_reg   <= wb[C0_RUN];
      ie_reg    <= wb[C0_IE];
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cap_sel_reg <= 2'h0;
      capture_irq_enable_reg    <= 1'b0;
      count_clock_select_reg    <= CK_SYSTEM;
      event_source_select_reg   <= 1'b0;
      pr_reg      <= PRE_RESET;
    end
    else
    begin
      if (w_c1)
      begin
        cap_sel_reg <= wb[C1_SEL_HI:C1_SEL_LO];
        capture_irq_enable_reg    <= wb[C1_CAPTURE_IRQ_ENABLE];
      end
      if (w_c2)
      begin
        count_clock_select_reg  <= wb[C2_CK_HI:C2_CK_LO];
        event_source_select_reg <= wb[C2_EVENT_SOURCE_SELECT];
        pr_reg    <= wb[C2_PR_HI:0];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      flg_reg   <= 1'b0;
      high_match_flag_reg  <= 1'b0;
      lcflg_reg <= 1'b0;
      hcflg_reg <= 1'b0;
      irq_request <= 1'b0;
    end
    else
    begin
      flg_reg   <= flg_next;
      high_match_flag_reg  <= high_match_flag_next;
      lcflg_reg <= lcflg_next;
      hcflg_reg <= hcflg_next;
      irq_request <= irq_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pre_reg    <= PRE_RESET;
      lcnt_reg   <= BYTE_RESET;
      hcnt_reg   <= BYTE_RESET;
      lbuf_reg   <= BYTE_RESET;
      hbuf_reg   <= BYTE_RESET;
      lcap_reg   <= BYTE_RESET;
      hcap_reg   <= BYTE_RESET;
      low_match  <= 1'b0;
      high_match <= 1'b0;
    end
    else
    begin
      pre_reg    <= pre_next;
      lcnt_reg   <= lcnt_next;
      hcnt_reg   <= hcnt_next;
      lbuf_reg   <= lbuf_next;
      hbuf_reg   <= hbuf_next;
      lcap_reg   <= lcap_next;
      hcap_reg   <= hcap_next;
      low_match  <= low_hit;
      high_match <= high_hit;
    end
  end

endmodule
`default_nettype wire

/* File: tb/match_timer_properties.sv */
// assertions on the bus port and covers on the match, interrupt and error outputs of the match timer
`timescale 1ns/1ps
`default_nettype none
module match_timer_properties
  import match_timer_pkg::*;
(
  input wire logic               clk,
  input wire logic               srst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [PDATA_W-1:0] prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               irq_request,
  input wire logic               low_match,
  input wire logic               high_match
);
  // ****************************************
  // helpers
  // ****************************************
  wire logic        acc = psel && penable && !pready;
  wire logic [15:0] idx = paddr[17:2];
  wire logic        bad = paddr[1:0] != 2'h0 || idx < IDX_LOW_RELOAD || idx > IDX_CLK_CTRL;
  wire logic        cnt = idx == IDX_LOW_COUNT || idx == IDX_HIGH_COUNT;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ****************************************
  // assertions
  // ****************************************
  a_ready_follows:
    assert property (acc |=> pready) else $error("no ready after access");
  a_ready_single:
    assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_ready_cause:
    assert property ($rose(pready) |-> $past(psel) && $past(penable))
      else $error("ready without access");
  a_rdata_idle:
    assert property (!pready |-> prdata == 32'h0) else $error("read data when idle");
  a_rdata_byte:
    assert property (prdata[31:8] == 24'h0) else $error("upper read data set");
  a_err_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  a_unmapped_err:
    assert property (acc && bad |=> pslverr) else $error("unmapped access accepted");
  a_count_ro:
    assert property (acc && pwrite && cnt && !bad |=> pready && !pslverr)
      else $error("count write refused");
  c_low: cover property (low_match);
  c_high: cover property (high_match);
  c_irq: cover property (irq_request);
  c_err: cover property (pslverr);
endmodule
`default_nettype wire

/* File: tb/event_source.sv */
// model of the external event pins and oscillators
`timescale 1ns/1ps
`default_nettype none
module event_source (
  input  wire logic       clk,
  output logic      [5:0] pins,
  output logic      [1:0] osc
);
  // lines 0 to 5 are the event pins, 6 and 7 the oscillators
  logic [7:0] drv;
  assign pins = drv[5:0];
  assign osc  = drv[7:6];
  initial
  begin
    drv = 8'h00;
  end
  // pulse long enough to pass the synchronisers, then back to idle low
  task automatic pulse(input int k);
    @(posedge clk);
    drv[k] <= 1'b1;
    repeat (4) @(posedge clk);
    drv[k] <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/match_timer_bench.sv */
// self-checking bench for the dual byte match timer
`timescale 1ns/1ps
`default_nettype none
module match_timer_bench
  import match_timer_pkg::*;
;
  logic               clk;
  logic               srst;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [PDATA_W-1:0] pwdata;
  logic [3:0]         pstrb;
  logic [PDATA_W-1:0] prdata;
  logic               pready;
  logic               pslverr;
  logic [5:0]         pins;
  logic [1:0]         osc;
  logic               irq_request;
  logic               low_match;
  logic               high_match;
  logic [31:0]        rd;
  logic               er;
  logic [7:0]         cap;
  int                 n_fail;
  int                 cmp_count;
  int                 i;
  int                 n;
  int                 lo_pin [4] = '{0, 2, 4, 5};
  int                 hi_pin [4] = '{1, 3, 5, 4};
  logic [7:0]         ck_val [3] = '{8'h60, 8'h80, 8'h40};
  logic [7:0]         run_val [3] = '{8'h04, 8'h04, 8'h14};
  int                 ev_pin [3] = '{3, 6, 2};
  int                 decoy [3] = '{2, 7, 3};

  match_timer u_match_timer (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_pin_zero(pins[0]), .event_pin_one(pins[1]),
    .event_pin_two(pins[2]), .event_pin_three(pins[3]), .event_pin_four(pins[4]),
    .event_pin_five(pins[5]), .aux_oscillator_zero(osc[0]), .aux_oscillator_one(osc[1]),
    .irq_request(irq_request), .low_match(low_match), .high_match(high_match));
  event_source u_event_source (.clk(clk), .pins(pins), .osc(osc));

  always #2 clk = ~clk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [15:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr_en;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
    begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask
  // cycles between two successive match pulses
  task automatic period(input bit hi, output int p);
    int k;
    for (k = 0; k < 2000; k++)
    begin
      @(posedge clk);
      if ((hi ? high_match : low_match) === 1'b1)
        break;
    end
    for (p = 1; p < 2000; p++)
    begin
      @(posedge clk);
      if ((hi ? high_match : low_match) === 1'b1)
        break;
    end
    if (p == 2000)
    begin
      n_fail++;
      print_verdict();
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0; srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pstrb = 4'hF; n_fail = 0; cmp_count = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 7; i++)
      rdc("reset value", IDX_LOW_RELOAD + 16'(i), 32'h0);
    apb(1'b0, 16'h7F1F, 8'h00);
    chk("unmapped error", 32'(er), 32'h1);
    $display("test reset and map done");
    wr(IDX_LOW_RELOAD, 8'h5A);
    wr(IDX_HIGH_RELOAD, 8'hA5);
    wr(IDX_LOW_COUNT, 8'hFF);
    pstrb <= 4'h0;
    wr(IDX_LOW_RELOAD, 8'h11);
    pstrb <= 4'hF;
    rdc("low reload", IDX_LOW_RELOAD, 32'h5A);
    rdc("high reload", IDX_HIGH_RELOAD, 32'hA5);
    rdc("count low", IDX_LOW_COUNT, 32'h0);
    wr(IDX_CAP_CTRL, 8'hFF);
    rdc("capture control", IDX_CAP_CTRL, 32'h19);
    wr(IDX_CLK_CTRL, 8'hFF);
    rdc("clock control", IDX_CLK_CTRL, 32'hEF);
    wr(IDX_CAP_CTRL, 8'h00);
    $display("test access kinds done");
    wr(IDX_LOW_RELOAD, 8'h03);
    wr(IDX_HIGH_RELOAD, 8'h00);
    wr(IDX_CLK_CTRL, 8'h01);
    wr(IDX_RUN_CTRL, 8'h05);
    period(1'b0, n);
    chk("period 16 bit", n, 8);
    rdc("low flag", IDX_RUN_CTRL, 32'h07);
    chk("low irq", 32'(irq_request), 32'h1);
    wr(IDX_LOW_RELOAD, 8'h07);
    period(1'b0, n);
    period(1'b0, n);
    chk("period reloaded", n, 16);
    wr(IDX_RUN_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    chk("low irq cleared", 32'(irq_request), 32'h0);
    rdc("stopped count", IDX_LOW_COUNT, 32'h0);
    $display("test 16 bit timer done");
    wr(IDX_HIGH_RELOAD, 8'h02);
    wr(IDX_CLK_CTRL, 8'h00);
    wr(IDX_RUN_CTRL, 8'hB0);
    period(1'b1, n);
    chk("period high", n, 3);
    rdc("high flag", IDX_RUN_CTRL, 32'hF0);
    chk("high irq", 32'(irq_request), 32'h1);
    rdc("low idle", IDX_LOW_COUNT, 32'h0);
    wr(IDX_RUN_CTRL, 8'h30);
    repeat (3) @(posedge clk);
    chk("high irq cleared", 32'(irq_request), 32'h0);
    $display("test split high done");
    for (i = 0; i < 4; i++)
    begin
      wr(IDX_CAP_CTRL, 8'(i * 8 + 1));
      u_event_source.pulse(lo_pin[i]);
      repeat (6) @(posedge clk);
      rdc("low capture flag", IDX_CAP_CTRL, 32'(i * 8 + 3));
      chk("capture irq", 32'(irq_request), 32'h1);
      u_event_source.pulse(hi_pin[i]);
      repeat (6) @(posedge clk);
      rdc("high capture flag", IDX_CAP_CTRL, 32'(i * 8 + 7));
    end
    wr(IDX_RUN_CTRL, 8'h00);
    wr(IDX_CAP_CTRL, 8'h00);
    u_event_source.pulse(0);
    u_event_source.pulse(1);
    repeat (6) @(posedge clk);
    rdc("16 bit capture flags", IDX_CAP_CTRL, 32'h02);
    wr(IDX_LOW_RELOAD, 8'hFF);
    wr(IDX_CLK_CTRL, 8'h0F);
    wr(IDX_RUN_CTRL, 8'h04);
    repeat (100) @(posedge clk);
    u_event_source.pulse(0);
    repeat (6) @(posedge clk);
    wr(IDX_RUN_CTRL, 8'h0C);
    apb(1'b0, IDX_LOW_COUNT, 8'h00);
    cap = rd[7:0];
    chk("capture nonzero", 32'(cap >= 8'h05), 32'h1);
    wr(IDX_RUN_CTRL, 8'h04);
    apb(1'b0, IDX_LOW_COUNT, 8'h00);
    chk("capture recent", 32'((rd[7:0] - cap) <= 8'h02), 32'h1);
    $display("test capture done");
    // pin three events, oscillator zero, split direct pin two; one decoy line each
    for (i = 0; i < 3; i++)
    begin
      wr(IDX_RUN_CTRL, 8'h00);
      wr(IDX_CLK_CTRL, ck_val[i]);
      wr(IDX_RUN_CTRL, run_val[i]);
      u_event_source.pulse(ev_pin[i]);
      u_event_source.pulse(ev_pin[i]);
      u_event_source.pulse(decoy[i]);
      repeat (6) @(posedge clk);
      rdc("event count", IDX_LOW_COUNT, 32'h2);
    end
    $display("test clock sources done");
    print_verdict();
  end
endmodule

bind match_timer match_timer_properties u_props (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_request(irq_request), .low_match(low_match), .high_match(high_match));
`default_nettype wire
